// ===== smsr_defs.vh
// constants for the special mode and scratch register slice
`ifndef SMSR_DEFS_VH
`define SMSR_DEFS_VH

// frame layout, sixteen bits, most significant bit first
`define SMSR_FRAME_BITS     5'd16
`define SMSR_HDR_LAST_BIT   5'd2
`define SMSR_SEL_HI         15
`define SMSR_SEL_LO         14
`define SMSR_RRS_BIT        13
`define SMSR_RO_BIT         12
`define SMSR_DATA_HI        11

// values of frame_register_select
`define SMSR_SEL_SPECIAL    2'h1
`define SMSR_SEL_SCRATCH0   2'h2

// special mode field positions
`define SMSR_SDM_BIT        9
`define SMSR_ERROR_PIN_EMULATION_BIT      8
`define SMSR_WDS_HI         6
`define SMSR_WDS_LO         5
`define SMSR_TRIP_HI        4
`define SMSR_TRIP_LO        3
// writable special mode bits; reserved bits 11, 10, 7, 2..0 read zero
`define SMSR_SPECIAL_MASK   12'h378
`define SMSR_SPECIAL_RST    12'h000

// scratch zero: bit 11 is the identification flag
`define SMSR_IDENT_BIT      11
// identification code, type and version; value is arbitrary
`define SMSR_IDENT_CODE     11'h2A5

// bus fault code meaning no failure
`define SMSR_NO_FAULT       4'h0

// watchdog scale in half units: 1, 1.5, 2.5, 3.5
`define SMSR_WDS_X1         3'h2
`define SMSR_WDS_X1P5       3'h3
`define SMSR_WDS_X2P5       3'h5
`define SMSR_WDS_X3P5       3'h7

// core supply trip level in percent of nominal
`define SMSR_TRIP_90        7'h5A
`define SMSR_TRIP_80        7'h50
`define SMSR_TRIP_70        7'h46

`endif

// ===== smsr_pin_sync.v
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps

module smsr_pin_sync #(
	parameter RST_VAL = 1'b0
) (
	input  wire i_clk, // device clock
	input  wire i_rst, // synchronous reset, active high
	input  wire i_pin, // raw pin level
	output wire o_lvl  // filtered level
);

	reg s1_reg;
	reg s2_reg;
	reg s3_reg;
	reg lvl_reg;

	// the first stage feeds only the second, so a metastable
	// sample never reaches the comparison
	always @(posedge i_clk) begin
		if (i_rst) begin
			s1_reg  <= RST_VAL;
			s2_reg  <= RST_VAL;
			s3_reg  <= RST_VAL;
			lvl_reg <= RST_VAL;
		end else begin
			s1_reg <= i_pin;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (s2_reg == s3_reg) begin
				lvl_reg <= s3_reg; // change taken once stages agree
			end
		end
	end

	assign o_lvl = lvl_reg;

endmodule

// ===== smsr_regs.v
// serial register slice: special mode and scratch register zero
`timescale 1ns/100ps
`include "smsr_defs.vh"

module smsr_regs (
	input  wire        I_MCLK,                  // device clock, 100 MHz
	input  wire        I_RST,                   // synchronous reset, active high
	input  wire        I_SCS_N,                 // frame select pin, active low
	input  wire        I_SCK,                   // serial clock pin
	input  wire        I_SDI,                   // serial data in pin
	output wire        O_SDO,                   // serial data out
	output wire        O_SDO_OE,                // serial data out enable
	input  wire [11:0] I_IRQ_EN_FB,             // interrupt enable feedback
	input  wire [11:0] I_SYS_CFG_FB,            // system configuration feedback
	input  wire [3:0]  I_BUS_FAULT_DIAG_CODE,   // bus failure diagnosis field
	input  wire        I_EN_SW,                 // ordinary software enable level
	output wire        O_EN,                    // enable output
	output wire        O_SW_DEV_MODE_INIT,      // software development mode
	output wire        O_ERROR_PIN_EMULATION,   // emulation mode level
	output wire [1:0]  O_WDOG_SCALE_SEL,        // raw watchdog scale field
	output wire [2:0]  O_WDOG_SCALE_HALVES,     // watchdog factor in halves
	output wire [1:0]  O_CORE_SUPPLY_TRIP_LEVEL,// raw trip level field
	output wire [6:0]  O_CORE_TRIP_PCT,         // trip level, percent
	output wire [11:0] O_USER_SCRATCH_ZERO      // scratch zero contents
);

	// watchdog scale decode, in half units
	function [2:0] wds_halves;
		input [1:0] sel;
		begin
			case (sel)
				2'h0:    wds_halves = `SMSR_WDS_X1;
				2'h1:    wds_halves = `SMSR_WDS_X1P5;
				2'h2:    wds_halves = `SMSR_WDS_X2P5;
				default: wds_halves = `SMSR_WDS_X3P5;
			endcase
		end
	endfunction

	// core supply trip level decode, codes 00 and 11 both give 90
	function [6:0] trip_pct;
		input [1:0] sel;
		begin
			case (sel)
				2'h1:    trip_pct = `SMSR_TRIP_80;
				2'h2:    trip_pct = `SMSR_TRIP_70;
				default: trip_pct = `SMSR_TRIP_90;
			endcase
		end
	endfunction

	wire        cs_n_lvl;
	wire        sck_lvl;
	wire        sdi_lvl;
	wire        cs_act;
	wire        sck_rise;
	wire        sck_fall;
	wire        frame_start;
	wire        frame_end;
	wire [2:0]  hdr;
	wire        wr_ok;

	reg         cs_act_reg;
	reg         sck_reg;
	reg  [4:0]  bit_cnt_reg;
	reg  [15:0] rx_reg;
	reg  [12:0] tx_reg;
	reg         sdo_reg;
	reg  [11:0] special_reg;
	reg  [11:0] scratch0_reg;
	reg  [11:0] rd_data;
	reg         en_reg;
	reg  [2:0]  wds_reg;
	reg  [6:0]  trip_reg;

	// pins come from the host's domain, so each goes through the filter
	smsr_pin_sync #(.RST_VAL(1'b1)) u_sync_cs (
		.i_clk (I_MCLK),
		.i_rst (I_RST),
		.i_pin (I_SCS_N),
		.o_lvl (cs_n_lvl)
	);

	smsr_pin_sync #(.RST_VAL(1'b0)) u_sync_sck (
		.i_clk (I_MCLK),
		.i_rst (I_RST),
		.i_pin (I_SCK),
		.o_lvl (sck_lvl)
	);

	smsr_pin_sync #(.RST_VAL(1'b0)) u_sync_sdi (
		.i_clk (I_MCLK),
		.i_rst (I_RST),
		.i_pin (I_SDI),
		.o_lvl (sdi_lvl)
	);

	// edges of the filtered frame select and serial clock; the edge
	// registers reset to the idle pin levels (select high, clock low),
	// so releasing reset never shows a false frame start or clock edge.
	// a serial half period must last several device clocks because the
	// filter adds three to four cycles of delay to every pin
	assign cs_act      = ~cs_n_lvl;
	assign frame_start = cs_act & ~cs_act_reg;
	assign frame_end   = ~cs_act & cs_act_reg;
	assign sck_rise    = cs_act & sck_lvl & ~sck_reg;
	assign sck_fall    = cs_act & ~sck_lvl & sck_reg;

	// address and readback select as known after the third bit
	assign hdr = {rx_reg[1:0], sdi_lvl};

	always @(posedge I_MCLK) begin
		if (I_RST) begin
			cs_act_reg <= 1'b0;
			sck_reg    <= 1'b0;
		end else begin
			cs_act_reg <= cs_act;
			sck_reg    <= sck_lvl;
		end
	end

	// readback mux; feedback is the live control register, so a frame
	// that stores reads back the value from before its own store.
	// unused addresses read zero rather than a stale register
	always @* begin
		rd_data = 12'h000;
		case (hdr)
			{`SMSR_SEL_SPECIAL, 1'b0}:  rd_data = I_IRQ_EN_FB;
			{`SMSR_SEL_SPECIAL, 1'b1}:  rd_data = special_reg;
			{`SMSR_SEL_SCRATCH0, 1'b0}: rd_data = I_SYS_CFG_FB;
			{`SMSR_SEL_SCRATCH0, 1'b1}: rd_data = scratch0_reg;
			default:                    rd_data = 12'h000;
		endcase
	end

	// receive shifter: data sampled on the rising serial clock, msb first
	always @(posedge I_MCLK) begin
		if (I_RST) begin
			rx_reg      <= 16'h0000;
			bit_cnt_reg <= 5'h00;
		end else if (frame_start) begin
			rx_reg      <= 16'h0000;
			bit_cnt_reg <= 5'h00;
		end else if (sck_rise) begin
			rx_reg <= {rx_reg[14:0], sdi_lvl};
			if (bit_cnt_reg != 5'h1F) begin
				bit_cnt_reg <= bit_cnt_reg + 5'h01; // saturates on long frames
			end
		end
	end

	// transmit shifter: answer loaded once the header is in, driven out
	// on falling edges so it is stable for the host's rising sample
	always @(posedge I_MCLK) begin
		if (I_RST) begin
			tx_reg  <= 13'h0000;
			sdo_reg <= 1'b0;
		end else if (frame_start) begin
			tx_reg  <= 13'h0000;
			sdo_reg <= 1'b0;
		end else if (sck_rise && bit_cnt_reg == `SMSR_HDR_LAST_BIT) begin
			tx_reg <= {1'b0, rd_data};
		end else if (sck_fall) begin
			sdo_reg <= tx_reg[12];
			tx_reg  <= {tx_reg[11:0], 1'b0};
		end
	end

	assign O_SDO    = sdo_reg;
	assign O_SDO_OE = cs_act_reg;

	// a store needs a complete frame with the read-only bit cleared;
	// short or long frames are dropped so a glitch cannot corrupt setup
	assign wr_ok = frame_end && (bit_cnt_reg == `SMSR_FRAME_BITS)
		&& !rx_reg[`SMSR_RO_BIT];

	// special mode register; reserved bits are not stored and read zero,
	// so a host that breaks the zero-write convention sees no effect
	always @(posedge I_MCLK) begin
		if (I_RST) begin
			special_reg <= `SMSR_SPECIAL_RST;
		end else if (wr_ok &&
			rx_reg[`SMSR_SEL_HI:`SMSR_SEL_LO] == `SMSR_SEL_SPECIAL) begin
			special_reg <= rx_reg[`SMSR_DATA_HI:0] & `SMSR_SPECIAL_MASK;
		end
	end

	// scratch zero: reset loads the identification code with the flag
	// clear, and any write forces the flag set
	always @(posedge I_MCLK) begin
		if (I_RST) begin
			scratch0_reg <= {1'b0, `SMSR_IDENT_CODE};
		end else if (wr_ok &&
			rx_reg[`SMSR_SEL_HI:`SMSR_SEL_LO] == `SMSR_SEL_SCRATCH0) begin
			scratch0_reg <= {1'b1, rx_reg[10:0]};
		end
	end

	// enable output: fault indicator under emulation, else the software
	// enable; registered so the pin never shows a decode glitch
	always @(posedge I_MCLK) begin
		if (I_RST) begin
			en_reg <= 1'b0;
		end else if (special_reg[`SMSR_ERROR_PIN_EMULATION_BIT]) begin
			en_reg <= (I_BUS_FAULT_DIAG_CODE == `SMSR_NO_FAULT);
		end else begin
			en_reg <= I_EN_SW;
		end
	end

	// decoded watchdog scale and trip level for the timing blocks; one
	// extra cycle of lag was accepted so the timing blocks see clean
	// registered codes instead of a combinational decode
	always @(posedge I_MCLK) begin
		if (I_RST) begin
			wds_reg  <= `SMSR_WDS_X1;
			trip_reg <= `SMSR_TRIP_90;
		end else begin
			wds_reg  <= wds_halves(special_reg[`SMSR_WDS_HI:`SMSR_WDS_LO]);
			trip_reg <= trip_pct(special_reg[`SMSR_TRIP_HI:`SMSR_TRIP_LO]);
		end
	end

	// mode levels straight from the stored register; decoded fields, enable and scratch from their own registers
	assign O_SW_DEV_MODE_INIT       = special_reg[`SMSR_SDM_BIT];
	assign O_ERROR_PIN_EMULATION    = special_reg[`SMSR_ERROR_PIN_EMULATION_BIT];
	assign O_WDOG_SCALE_SEL         = special_reg[`SMSR_WDS_HI:`SMSR_WDS_LO];
	assign O_WDOG_SCALE_HALVES      = wds_reg;
	assign O_CORE_SUPPLY_TRIP_LEVEL = special_reg[`SMSR_TRIP_HI:`SMSR_TRIP_LO];
	assign O_CORE_TRIP_PCT          = trip_reg;
	assign O_EN                     = en_reg;
	assign O_USER_SCRATCH_ZERO      = scratch0_reg;

endmodule

// ===== smsr_regs_chk.sv
// port assertions for the register slice
`timescale 1ns/100ps
module smsr_regs_chk (
	input logic        I_MCLK,                   // clock
	input logic        I_RST,                    // reset
	input logic        I_SCS_N,                  // select
	input logic [3:0]  I_BUS_FAULT_DIAG_CODE,    // fault code
	input logic        I_EN_SW,                  // sw enable
	input logic        O_SDO_OE,                 // frame busy
	input logic        O_EN,                     // enable
	input logic        O_SW_DEV_MODE_INIT,       // bit 9
	input logic        O_ERROR_PIN_EMULATION,    // bit 8
	input logic [1:0]  O_WDOG_SCALE_SEL,         // bits 6..5
	input logic [2:0]  O_WDOG_SCALE_HALVES,      // factor
	input logic [1:0]  O_CORE_SUPPLY_TRIP_LEVEL, // bits 4..3
	input logic [6:0]  O_CORE_TRIP_PCT,          // percent
	input logic [11:0] O_USER_SCRATCH_ZERO       // scratch
);
	default clocking cb @(posedge I_MCLK); endclocking
	default disable iff (I_RST);
	// enable path, one cycle behind its causes
	property p_en_emul;
		!$past(I_RST) && $past(O_ERROR_PIN_EMULATION) |-> O_EN == ($past(I_BUS_FAULT_DIAG_CODE) == 4'h0);
	endproperty
	a_en_emul: assert property (p_en_emul) else $error("enable in emulation");
	property p_en_sw;
		!$past(I_RST) && !$past(O_ERROR_PIN_EMULATION) |-> O_EN == $past(I_EN_SW);
	endproperty
	a_en_sw: assert property (p_en_sw) else $error("plain enable");
	// decoded fields lag the raw field by one edge; 2,3,5,7 halves
	property p_halves;
		!$past(I_RST) |-> O_WDOG_SCALE_HALVES == ($past(O_WDOG_SCALE_SEL) == 2'h0 ? 3'h2 : {$past(O_WDOG_SCALE_SEL), 1'b1});
	endproperty
	a_halves: assert property (p_halves) else $error("scale factor");
	property p_pct;
		!$past(I_RST) |-> O_CORE_TRIP_PCT == ($past(O_CORE_SUPPLY_TRIP_LEVEL) == 2'h1 ? 7'h50 : $past(O_CORE_SUPPLY_TRIP_LEVEL) == 2'h2 ? 7'h46 : 7'h5A);
	endproperty
	a_pct: assert property (p_pct) else $error("trip level");
	// stores land only as a frame closes
	property p_sc_when;
		!$past(I_RST) && $changed(O_USER_SCRATCH_ZERO) |-> !O_SDO_OE && $past(O_SDO_OE, 2);
	endproperty
	a_sc_when: assert property (p_sc_when) else $error("scratch store time");
	property p_sc_flag;
		!$past(I_RST) && $changed(O_USER_SCRATCH_ZERO) |-> O_USER_SCRATCH_ZERO[11];
	endproperty
	a_sc_flag: assert property (p_sc_flag) else $error("flag not set");
	property p_mode_when;
		!$past(I_RST) && $changed({O_SW_DEV_MODE_INIT, O_ERROR_PIN_EMULATION, O_WDOG_SCALE_SEL, O_CORE_SUPPLY_TRIP_LEVEL}) |-> !O_SDO_OE && $past(O_SDO_OE, 2);
	endproperty
	a_mode_when: assert property (p_mode_when) else $error("mode store time");
	property p_oe_busy;
		!I_SCS_N [*8] |-> O_SDO_OE;
	endproperty
	a_oe_busy: assert property (p_oe_busy) else $error("frame not active");
endmodule

// ===== smsr_host.sv
// host model: serial master issuing register frames
`timescale 1ns/100ps
module smsr_host (
	input  logic i_clk,   // device clock
	input  logic i_sdo,   // answer line
	output logic o_scs_n, // select, idle high
	output logic o_sck,   // serial clock, idle low
	output logic o_sdi    // data to device
);
	// idle levels; clock stands still outside frames
	initial begin
		o_scs_n = 1;
		o_sck = 0;
		o_sdi = 0;
	end
	// nb bits msb first, answer taken just before each rise
	task automatic xfer(input logic [15:0] w, input int nb, input int hp, output logic [15:0] r);
		r = 16'h0000;
		@(negedge i_clk) o_scs_n = 0;
		repeat (hp) @(negedge i_clk);
		for (int i = 15; i > 15 - nb; i--) begin
			o_sdi = w[i];
			repeat (hp) @(negedge i_clk);
			r[i] = i_sdo;
			o_sck = 1;
			repeat (hp) @(negedge i_clk);
			o_sck = 0;
		end
		// released data flips so a stale bit cannot pass as good
		o_sdi = ~o_sdi;
		repeat (hp) @(negedge i_clk);
		o_scs_n = 1;
		repeat (8) @(negedge i_clk);
	endtask
endmodule

// ===== test_special_mode_and_scratch_regs.sv
// self-checking bench for the special mode and scratch slice
`timescale 1ns/100ps
`include "smsr_defs.vh"
module test_special_mode_and_scratch_regs;
	logic clk = 0, rst = 1, en_sw = 0;
	logic [11:0] irq = 0, cfg = 0, sp, sc;
	logic [3:0] code = 0;
	wire scs_n, sck, sdi, sdo, oe, en, sdm, erm;
	wire [1:0] wsel, tsel;
	wire [2:0] hv;
	wire [6:0] pct;
	wire [11:0] scr;
	int fails = 0, samples_checked = 0;
	// free-running device clock
	always #5 clk = ~clk;
	smsr_regs smsr_regs_inst (.I_MCLK(clk), .I_RST(rst), .I_SCS_N(scs_n), .I_SCK(sck),
		.I_SDI(sdi), .O_SDO(sdo), .O_SDO_OE(oe), .I_IRQ_EN_FB(irq), .I_SYS_CFG_FB(cfg),
		.I_BUS_FAULT_DIAG_CODE(code), .I_EN_SW(en_sw), .O_EN(en), .O_SW_DEV_MODE_INIT(sdm),
		.O_ERROR_PIN_EMULATION(erm), .O_WDOG_SCALE_SEL(wsel), .O_WDOG_SCALE_HALVES(hv),
		.O_CORE_SUPPLY_TRIP_LEVEL(tsel), .O_CORE_TRIP_PCT(pct), .O_USER_SCRATCH_ZERO(scr));
	smsr_host smsr_host_inst (.i_clk(clk), .i_sdo(sdo), .o_scs_n(scs_n), .o_sck(sck), .o_sdi(sdi));
	// compare and count
	task chk(input logic [27:0] seen, input logic [27:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	function logic [2:0] hvf(input logic [1:0] s);
		return s == 2'h0 ? 3'h2 : {s, 1'b1};
	endfunction
	function logic [6:0] pcf(input logic [1:0] s);
		return s == 2'h1 ? 7'h50 : s == 2'h2 ? 7'h46 : 7'h5A;
	endfunction
	// one frame against the reference state, then outputs and enable
	task frm(input logic [1:0] s, input logic r, input logic ro, input logic [11:0] d, input int nb);
		logic [15:0] got;
		logic [11:0] e;
		if (s == 2'h1) d &= 12'h378;
		irq = 12'($urandom);
		cfg = 12'($urandom);
		e = s == 2'h1 ? (r ? sp : irq) : s == 2'h2 ? (r ? sc : cfg) : 12'h000;
		smsr_host_inst.xfer({s, r, ro, d}, nb, 7 + 5 * $urandom_range(1), got);
		if (nb == 16) chk(28'(got), 28'(e));
		if (nb == 16 && !ro && s == 2'h1) sp = d;
		if (nb == 16 && !ro && s == 2'h2) sc = {1'b1, d[10:0]};
		chk({scr, sdm, erm, wsel, tsel, hv, pct}, {sc, sp[9:8], sp[6:3], hvf(sp[6:5]), pcf(sp[4:3])});
		code = $urandom_range(1) ? 4'h0 : 4'($urandom);
		en_sw = 1'($urandom);
		repeat (2) @(negedge clk);
		chk(28'(en), 28'(sp[8] ? code == 4'h0 : en_sw));
	endtask
	task test_done;
		$display("checked %0d, mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// main sequence: reset, corners, random frames, reset again
	initial begin
		void'($urandom(32'h4E32A186));
		sp = 12'h000;
		sc = {1'b0, `SMSR_IDENT_CODE};
		repeat (10) @(negedge clk);
		rst = 0;
		frm(2'h2, 1, 1, 12'h000, 16);
		$display("reset test done");
		for (int i = 0; i < 16; i++) frm(2'h1, 1, 0, {2'h0, 2'($urandom), 1'b0, 4'(i), 3'h0}, 16);
		frm(2'h1, 1, 1, 12'h378, 16);
		frm(2'h1, 0, 0, 12'h000, 16);
		frm(2'h2, 1, 0, 12'h5A5, 16);
		frm(2'h2, 0, 1, 12'hFFF, 16);
		frm(2'h2, 1, 0, 12'h0F0, 15);
		$display("corner test done");
		for (int i = 0; i < 30; i++) frm(2'($urandom), 1'($urandom), 1'($urandom), 12'($urandom), 16);
		$display("random test done");
		rst = 1;
		repeat (4) @(negedge clk);
		rst = 0;
		sp = 12'h000;
		sc = {1'b0, `SMSR_IDENT_CODE};
		repeat (4) @(negedge clk);
		frm(2'h2, 1, 1, 12'h000, 16);
		$display("second reset test done");
		test_done;
	end
	// watchdog well beyond the expected run length
	initial begin
		repeat (40000) @(posedge clk);
		fails++;
		test_done;
	end
endmodule
bind smsr_regs smsr_regs_chk smsr_regs_chk_inst (.I_MCLK, .I_RST, .I_SCS_N, .I_BUS_FAULT_DIAG_CODE,
	.I_EN_SW, .O_SDO_OE, .O_EN, .O_SW_DEV_MODE_INIT, .O_ERROR_PIN_EMULATION, .O_WDOG_SCALE_SEL,
	.O_WDOG_SCALE_HALVES, .O_CORE_SUPPLY_TRIP_LEVEL, .O_CORE_TRIP_PCT, .O_USER_SCRATCH_ZERO);
